// ==== design/crph_pkg.sv ====
// Purpose: Shared constants and types for the card reader-punch host port.
// Assumes: Host words are sixteen bits, bit 1 is the most significant bit.
// Notes: Control word positions are given as vector indices, bit 1 at index 15.
package crph_pkg;
	// Width of a host word.
	localparam int CRPH_WORD_W = 16;
	// Clock rate of the system clock pulse in MHz.
	localparam int CRPH_CLK_MHZ = 1;
	// Control word bit positions (index 15 is documented bit 1).
	localparam int CRPH_CW_OPER_ALERT = 15;
	localparam int CRPH_CW_DIS_STATUS = 14;
	localparam int CRPH_CW_CLEAR = 13;
	localparam int CRPH_CW_TERM = 12;
	localparam int CRPH_CW_SEP_PRINT = 8;
	localparam int CRPH_CW_INH_FEED = 7;
	localparam int CRPH_CW_PRINT = 6;
	localparam int CRPH_CW_PUNCH = 5;
	localparam int CRPH_CW_START = 0;
	// Stacker select field, bits 5 to 7.
	localparam int CRPH_CW_STKR_LO = 9;
	// Mask of output lines that exist: bits 3 and 4 are absent.
	localparam logic [15:0] CRPH_OUT_MASK = 16'hCFFF;
	// Reset value of every captured word.
	localparam logic [15:0] CRPH_WORD_RST = 16'h0000;
	// Status word layout: bit 1 data request, bit 2 operator request.
	localparam int CRPH_ST_DATA_REQ = 15;
	localparam int CRPH_ST_OPER_REQ = 14;
	// Card motion sequence.
	typedef enum logic [2:0] {
		CRPH_IDLE = 3'b000,
		CRPH_LOAD = 3'b001,
		CRPH_PUNCH = 3'b010,
		CRPH_HOLD = 3'b011,
		CRPH_STACK = 3'b100
	} crph_state_t;
	// One host transfer request, all active high after inversion.
	typedef struct packed {
		logic wr;
		logic rd;
		logic st;
		logic ctl;
	} crph_req_t;
endpackage : crph_pkg

// ==== design/crph_host_port.sv ====
// Purpose: Host-side port and card motion sequencer of the reader-punch controller.
// Assumes: Host strobes and lines are synchronous to MCLK; all but SYSTEM_CLEAR are active low.
// Notes: The peripheral answers with active-low progress signals.
// How it works
// - Write strobe captures one host word.
// - Read strobe drives one word out.
// - Status enable sends status word out.
// - Instruction line marks word as control.
// - System clear resets every control flip-flop.
// - Data interrupt low when transfer wanted.
// - Status interrupt low when status waits.
// - Logic runs on the system clock.
// - Sixteen inputs; outputs 1,2,5-16 only.
// - Peripheral signals are all active low.
// - Punch/print control moves card to stacker.
// - Mid punch, next card may feed.
// - Punch data loaded before card leaves.
// - Separate print holds card for data.
// - Instruction picks control/data or status/data.
// - One-cycle words captured into buffers.
// - Host enables or disables each interrupt.
`timescale 1ns/1ps
`default_nettype none
module crph_host_port
	import crph_pkg::*;
#(
	parameter int WORD_W = CRPH_WORD_W
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic SYSTEM_CLEAR,
	input wire logic HOST_WRITE_STROBE_N,
	input wire logic HOST_READ_STROBE_N,
	input wire logic STATUS_TRANSFER_ENABLE_N,
	input wire logic CONTROL_WORD_FLAG_N,
	input wire logic [WORD_W-1:0] HOST_IN_N,
	output logic [WORD_W-1:0] HOST_OUT_N,
	output logic DATA_SERVICE_IRQ_N,
	output logic STATUS_SERVICE_IRQ_N,
	input wire logic [WORD_W-1:0] PERIPH_DATA_IN_N,
	input wire logic PERIPH_DATA_VALID_N,
	input wire logic PERIPH_NOT_READY_N,
	input wire logic PERIPH_HOPPER_EMPTY_N,
	input wire logic PERIPH_PUNCH_HALF_N,
	input wire logic PERIPH_CARD_STACKED_N,
	output logic [WORD_W-1:0] PERIPH_DATA_OUT_N,
	output logic PERIPH_LOAD_BUFFER_N,
	output logic PERIPH_FEED_CARD_N,
	output logic PERIPH_NEXT_FEED_N,
	output logic [2:0] PERIPH_STACKER_N
);
	// Requests after inversion; the host lines are active low.
	crph_req_t req;
	assign req.wr = ~HOST_WRITE_STROBE_N;
	assign req.rd = ~HOST_READ_STROBE_N;
	assign req.st = ~STATUS_TRANSFER_ENABLE_N;
	assign req.ctl = ~CONTROL_WORD_FLAG_N;

	// System clear resets everything; the clear bit of a control word spares the buffers.
	wire logic clr = SYSTEM_CLEAR;
	wire logic [WORD_W-1:0] in_word = ~HOST_IN_N;
	wire logic ctl_wr = req.wr & req.ctl;
	wire logic data_wr = req.wr & ~req.ctl;
	wire logic stat_rd = (req.rd & req.ctl) | req.st;
	wire logic data_rd = req.rd & ~req.ctl & ~req.st;
	wire logic soft_clr = ctl_wr & in_word[CRPH_CW_CLEAR];

	// Captured buffers and flags.
	logic [WORD_W-1:0] ctl_q; // Last control word.
	logic [WORD_W-1:0] wbuf_q; // Punch/print data held for the peripheral.
	logic [WORD_W-1:0] rbuf_q; // Read data waiting for the host.
	logic [WORD_W-1:0] out_q; // Word presented on the output lines.
	logic wbuf_full_q; // Data buffer holds a word not yet loaded.
	logic rbuf_full_q; // Read buffer holds a word for the host.
	logic stat_pend_q; // A status condition waits for the host.
	logic data_service_irq_en_q; // Data interrupt enabled.
	logic status_service_irq_en_q; // Status interrupt enabled.
	logic loaded_q; // Punch buffer received data for this card.
	crph_state_t state_q, state_d;

	// Status word: data request, operator request, device status field.
	wire logic hop_empty = ~PERIPH_HOPPER_EMPTY_N;
	wire logic not_ready = ~PERIPH_NOT_READY_N;
	wire logic data_req = ~wbuf_full_q | rbuf_full_q;
	// Hopper empty sits at status bit 12 (index 4) and not ready at bit 16 (index 0).
	// The device status bits are live levels: a condition gone before the read is not
	// shown, although the pending flag has already raised the interrupt for it.
	wire logic [WORD_W-1:0] status_word = {data_req, ctl_q[CRPH_CW_OPER_ALERT],
		9'h000, hop_empty, 3'h0, not_ready};
	wire logic stat_event = (hop_empty | not_ready) & ~stat_pend_q;

	// Card motion decode.
	wire logic pp_req = ctl_q[CRPH_CW_PUNCH] | ctl_q[CRPH_CW_PRINT];
	wire logic sep_print = ctl_q[CRPH_CW_SEP_PRINT] & ctl_q[CRPH_CW_PRINT];
	wire logic start_cw = ctl_wr & in_word[CRPH_CW_START] &
		(in_word[CRPH_CW_PUNCH] | in_word[CRPH_CW_PRINT]);

	// Next state of the card motion sequence.
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			CRPH_IDLE: if (start_cw) state_d = CRPH_LOAD;
			// Card may not leave the visible station until data is loaded.
			CRPH_LOAD: if (loaded_q) state_d = CRPH_PUNCH;
			CRPH_PUNCH: if (~PERIPH_PUNCH_HALF_N)
				state_d = sep_print ? CRPH_HOLD : CRPH_STACK;
			// Separate print: card waits in the punch station for print data.
			CRPH_HOLD: if (data_wr) state_d = CRPH_STACK;
			CRPH_STACK: if (~PERIPH_CARD_STACKED_N) state_d = CRPH_IDLE;
			default: state_d = CRPH_IDLE;
		endcase
	end

	// Buffers capture in the same cycle the strobe is seen, since words last one cycle.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ctl_q <= CRPH_WORD_RST;
			wbuf_q <= CRPH_WORD_RST;
			rbuf_q <= CRPH_WORD_RST;
			out_q <= CRPH_WORD_RST;
		end else if (clr) begin
			ctl_q <= CRPH_WORD_RST;
			wbuf_q <= CRPH_WORD_RST;
			rbuf_q <= CRPH_WORD_RST;
			out_q <= CRPH_WORD_RST;
		end else begin
			if (ctl_wr) ctl_q <= in_word;
			if (data_wr) wbuf_q <= in_word;
			if (~PERIPH_DATA_VALID_N) rbuf_q <= ~PERIPH_DATA_IN_N;
			// Absent output lines are forced inactive by the mask.
			if (stat_rd) out_q <= status_word & CRPH_OUT_MASK;
			else if (data_rd) out_q <= rbuf_q & CRPH_OUT_MASK;
		end
	end

	// Flags and sequencer; a new event wins over a clearing read.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			wbuf_full_q <= 1'b0;
			rbuf_full_q <= 1'b0;
			stat_pend_q <= 1'b0;
			data_service_irq_en_q <= 1'b0;
			status_service_irq_en_q <= 1'b0;
			loaded_q <= 1'b0;
			state_q <= CRPH_IDLE;
		end else if (clr | soft_clr) begin
			wbuf_full_q <= 1'b0;
			rbuf_full_q <= 1'b0;
			stat_pend_q <= 1'b0;
			data_service_irq_en_q <= 1'b0;
			status_service_irq_en_q <= 1'b0;
			loaded_q <= 1'b0;
			state_q <= CRPH_IDLE;
		end else begin
			state_q <= state_d;
			wbuf_full_q <= data_wr | (wbuf_full_q & ~(state_q == CRPH_LOAD));
			rbuf_full_q <= ~PERIPH_DATA_VALID_N | (rbuf_full_q & ~data_rd);
			stat_pend_q <= stat_event | (stat_pend_q & ~stat_rd);
			// A control word enables data service unless its terminate bit is set; the disable bit gates status.
			if (ctl_wr) data_service_irq_en_q <= ~in_word[CRPH_CW_TERM];
			if (ctl_wr) status_service_irq_en_q <= ~in_word[CRPH_CW_DIS_STATUS];
			loaded_q <= (state_q == CRPH_LOAD && wbuf_full_q) |
				(loaded_q & ~(state_q == CRPH_STACK));
		end
	end

	// Output drivers; all peripheral and host signals are active low.
	assign HOST_OUT_N = ~out_q;
	assign DATA_SERVICE_IRQ_N = ~(data_service_irq_en_q & data_req);
	assign STATUS_SERVICE_IRQ_N = ~(status_service_irq_en_q & stat_pend_q);
	assign PERIPH_DATA_OUT_N = ~wbuf_q;
	assign PERIPH_LOAD_BUFFER_N = ~(state_q == CRPH_LOAD && wbuf_full_q);
	// Feed stays asserted through stacking and, apart from a separate-print card in hold, drops only once the card is stacked,
	// so the peripheral must report the stacked card while feed is still low.
	assign PERIPH_FEED_CARD_N = ~(pp_req &&
		(state_q == CRPH_PUNCH || state_q == CRPH_STACK));
	assign PERIPH_NEXT_FEED_N = ~(state_q == CRPH_STACK &&
		~ctl_q[CRPH_CW_INH_FEED]);
	assign PERIPH_STACKER_N = ~ctl_q[CRPH_CW_STKR_LO +: 3];

	// Checks on the port behaviour.
	a_ctl_capture: assert property (@(posedge MCLK) disable iff (!RST_N)
		ctl_wr && !clr |=> ctl_q == $past(in_word))
		else $error("control word not captured");
	a_data_capture: assert property (@(posedge MCLK) disable iff (!RST_N)
		data_wr && !clr |=> wbuf_q == $past(in_word) && wbuf_full_q)
		else $error("data word not captured");
	a_status_out: assert property (@(posedge MCLK) disable iff (!RST_N)
		stat_rd && !clr |=> HOST_OUT_N == ~($past(status_word) & CRPH_OUT_MASK))
		else $error("status word not presented");
	a_clear_all: assert property (@(posedge MCLK) disable iff (!RST_N)
		clr |=> state_q == CRPH_IDLE && ctl_q == CRPH_WORD_RST && !stat_pend_q)
		else $error("clear left state");
	a_data_service_irq_mask: assert property (@(posedge MCLK) disable iff (!RST_N)
		!data_service_irq_en_q |-> DATA_SERVICE_IRQ_N)
		else $error("data interrupt while disabled");
	a_status_service_irq_level: assert property (@(posedge MCLK) disable iff (!RST_N)
		status_service_irq_en_q && stat_pend_q |-> !STATUS_SERVICE_IRQ_N)
		else $error("status interrupt missing");
	a_hold_print: assert property (@(posedge MCLK) disable iff (!RST_N)
		state_q == CRPH_HOLD && !data_wr && !clr && !soft_clr |=> state_q == CRPH_HOLD)
		else $error("card left punch station early");
	a_load_first: assert property (@(posedge MCLK) disable iff (!RST_N)
		state_q == CRPH_LOAD ##1 state_q == CRPH_PUNCH |-> $past(loaded_q))
		else $error("card moved before buffer load");
	a_mask_lines: assert property (@(posedge MCLK) disable iff (!RST_N)
		HOST_OUT_N[13:12] == 2'h3)
		else $error("absent output line driven");
	a_feed_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
		state_q == CRPH_HOLD |-> PERIPH_FEED_CARD_N)
		else $error("card moved while waiting for print data");
	a_next_inhibit: assert property (@(posedge MCLK) disable iff (!RST_N)
		ctl_q[CRPH_CW_INH_FEED] |-> PERIPH_NEXT_FEED_N)
		else $error("next card fed while feed inhibited");
	c_start: cover property (@(posedge MCLK) disable iff (!RST_N) start_cw);
	c_hold: cover property (@(posedge MCLK) disable iff (!RST_N) state_q == CRPH_HOLD);
	c_status: cover property (@(posedge MCLK) disable iff (!RST_N)
		!STATUS_SERVICE_IRQ_N ##1 stat_rd);
	c_sep_stack: cover property (@(posedge MCLK) disable iff (!RST_N)
		state_q == CRPH_HOLD ##1 state_q == CRPH_STACK);
endmodule : crph_host_port
`default_nettype wire

// ==== testbench/crph_periph_model.sv ====
// Purpose: Card peripheral stand-in answering a feed request with sensor levels.
// Assumes: Feed request is active low and comes from registered state.
// Notes: Fixed short delays; no data path is modelled.
`timescale 1ns/1ps
`default_nettype none
module crph_periph_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic feed_n,
	output logic punch_half_n,
	output logic stacked_n
);
	logic [3:0] cnt_q; // Cycles since feed last changed.
	logic feed_q; // Feed level seen last cycle.
	logic moved_q; // The card has passed half-way through the punch station.
	// Levels move at the falling edge so the design samples them settled.
	// Feed is held low from punching through stacking, except while a separate-print card
	// waits in hold, so the card is reported stacked a fixed number of cycles into a stretch of continuous feed.
	always @(negedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 4'h0;
			feed_q <= 1'b1;
			moved_q <= 1'b0;
			punch_half_n <= 1'b1;
			stacked_n <= 1'b1;
		end else begin
			feed_q <= feed_n;
			cnt_q <= (feed_n != feed_q) ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hF};
			if (!feed_n && cnt_q == 4'h3) begin
				moved_q <= 1'b1;
			end else if (!stacked_n) begin
				moved_q <= 1'b0;
			end
			punch_half_n <= !(!feed_n && cnt_q == 4'h3);
			stacked_n <= !(!feed_n && moved_q && cnt_q == 4'h7);
		end
	end
endmodule : crph_periph_model
`default_nettype wire

// ==== testbench/crph_host_port_tb_top.sv ====
// Purpose: Self-checking bench for the reader-punch host port.
// Assumes: Host lines change at the falling edge of MCLK.
// Notes: The watchdog ends a hung run through the same closing task.
`timescale 1ns/1ps
`default_nettype none
module crph_host_port_tb_top;
	import crph_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, clr = 1'b0, wr_n = 1'b1, rd_n = 1'b1, st_n = 1'b1;
	logic fl_n = 1'b1, pv_n = 1'b1, pnr_n = 1'b1, phe_n = 1'b1;
	logic [15:0] hin_n = 16'hFFFF, pdin_n = 16'hFFFF, hout_n, pdout_n;
	logic dirq_n, sirq_n, pload_n, pfeed_n, pnext_n, phalf_n, pdone_n;
	logic [2:0] pstk_n;
	int mismatches = 0, samples_checked = 0, i;
	always #10 clk = ~clk;
	crph_host_port u_crph_host_port (.MCLK(clk), .RST_N(rst_n), .SYSTEM_CLEAR(clr),
		.HOST_WRITE_STROBE_N(wr_n), .HOST_READ_STROBE_N(rd_n),
		.STATUS_TRANSFER_ENABLE_N(st_n), .CONTROL_WORD_FLAG_N(fl_n), .HOST_IN_N(hin_n),
		.HOST_OUT_N(hout_n), .DATA_SERVICE_IRQ_N(dirq_n), .STATUS_SERVICE_IRQ_N(sirq_n),
		.PERIPH_DATA_IN_N(pdin_n), .PERIPH_DATA_VALID_N(pv_n), .PERIPH_NOT_READY_N(pnr_n),
		.PERIPH_HOPPER_EMPTY_N(phe_n), .PERIPH_PUNCH_HALF_N(phalf_n),
		.PERIPH_CARD_STACKED_N(pdone_n), .PERIPH_DATA_OUT_N(pdout_n),
		.PERIPH_LOAD_BUFFER_N(pload_n), .PERIPH_FEED_CARD_N(pfeed_n),
		.PERIPH_NEXT_FEED_N(pnext_n), .PERIPH_STACKER_N(pstk_n));
	crph_periph_model u_crph_periph_model (.clk(clk), .rst_n(rst_n), .feed_n(pfeed_n),
		.punch_half_n(phalf_n), .stacked_n(pdone_n));
	// Compare one value of up to sixteen bits.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One host strobe lasting one cycle; the answer has landed on return.
	task automatic host(input logic [15:0] w, input logic wr, input logic ctl);
		@(negedge clk);
		hin_n <= ~w;
		wr_n <= !wr;
		rd_n <= wr;
		st_n <= wr || !ctl;
		fl_n <= !ctl;
		@(negedge clk);
		{wr_n, rd_n, st_n, fl_n} <= 4'hF;
		hin_n <= 16'hFFFF;
	endtask : host
	task automatic t_reset;
		chk(hout_n, 16'hFFFF);
		chk({13'h0, dirq_n, sirq_n, pload_n}, 16'h0007);
		chk({13'h0, pstk_n}, 16'h0007);
		$display("test reset done");
	endtask : t_reset
	task automatic t_status;
		host(16'h8000, 1'b1, 1'b1);
		chk({15'h0, dirq_n}, 16'h0000);
		phe_n <= 1'b0;
		repeat (2) @(negedge clk);
		chk({15'h0, sirq_n}, 16'h0000);
		// Status bits are live, so the hopper stays empty through the read.
		host(16'h0000, 1'b0, 1'b1);
		chk(hout_n | 16'h8000, 16'hBFEF);
		phe_n <= 1'b1;
		chk({15'h0, sirq_n}, 16'h0001);
		host(16'h4000, 1'b1, 1'b1);
		phe_n <= 1'b0;
		repeat (2) @(negedge clk);
		chk({15'h0, sirq_n}, 16'h0001);
		phe_n <= 1'b1;
		clr <= 1'b1;
		@(negedge clk);
		clr <= 1'b0;
		@(negedge clk);
		chk({14'h0, dirq_n, sirq_n}, 16'h0003);
		$display("test status done");
	endtask : t_status
	task automatic t_read;
		host(16'h0000, 1'b1, 1'b1);
		@(negedge clk);
		pdin_n <= ~16'h3A5C;
		pv_n <= 1'b0;
		@(negedge clk);
		pv_n <= 1'b1;
		pdin_n <= 16'hFFFF;
		host(16'h0000, 1'b0, 1'b0);
		chk(hout_n, 16'hF5A3);
		pnr_n <= 1'b0;
		repeat (2) @(negedge clk);
		chk({15'h0, sirq_n}, 16'h0000);
		host(16'h0000, 1'b0, 1'b1);
		chk(hout_n, 16'h7FFE);
		pnr_n <= 1'b1;
		$display("test read done");
	endtask : t_read
	task automatic t_card;
		host(16'h0A21, 1'b1, 1'b1);
		chk({13'h0, pstk_n, pload_n}, 16'h0005);
		host(16'h1234, 1'b1, 1'b0);
		chk(pdout_n, ~16'h1234);
		chk({15'h0, pload_n}, 16'h0000);
		for (i = 0; i < 50 && pfeed_n !== 1'b0; i++) @(negedge clk);
		chk({15'h0, pfeed_n}, 16'h0000);
		for (i = 0; i < 50 && pnext_n !== 1'b0; i++) @(negedge clk);
		chk({15'h0, pnext_n}, 16'h0000);
		for (i = 0; i < 50 && pnext_n !== 1'b1; i++) @(negedge clk);
		chk({13'h0, pload_n, pfeed_n, pnext_n}, 16'h0007);
		$display("test card done");
	endtask : t_card
	// Separate print with input feed inhibited: the card waits for the print word.
	task automatic t_sep;
		host(16'h07C1, 1'b1, 1'b1);
		host(16'h00AB, 1'b1, 1'b0);
		chk({13'h0, pstk_n}, 16'h0004);
		for (i = 0; i < 50 && pfeed_n !== 1'b0; i++) @(negedge clk);
		chk({15'h0, pfeed_n}, 16'h0000);
		for (i = 0; i < 50 && pfeed_n !== 1'b1; i++) @(negedge clk);
		repeat (4) @(negedge clk);
		chk({14'h0, pfeed_n, pnext_n}, 16'h0003);
		host(16'h0055, 1'b1, 1'b0);
		chk(pdout_n, ~16'h0055);
		chk({14'h0, pfeed_n, pnext_n}, 16'h0001);
		for (i = 0; i < 50 && pfeed_n !== 1'b1; i++) @(negedge clk);
		chk({13'h0, pload_n, pfeed_n, pnext_n}, 16'h0007);
		$display("test separate print done");
	endtask : t_sep
	task automatic results;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results
	// Stops a hang well after the fewer than a hundred cycles the tests need.
	initial begin
		#400000;
		mismatches++;
		results();
	end
	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_status();
		t_read();
		t_card();
		t_sep();
		results();
	end
endmodule : crph_host_port_tb_top
`default_nettype wire
